// >>> rtl/vcs_pkg.sv
// constants and types shared by the calibration sequencer files
package vcs_pkg;

  // ----------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [9:0] IDX_CAL_CTRL = 10'h018;
  localparam logic [9:0] IDX_ZD_CTRL  = 10'h01E;
  localparam logic [9:0] IDX_STATUS   = 10'h01F;
  localparam logic [9:0] IDX_VCO_DIV  = 10'h1E0;
  localparam logic [9:0] IDX_UPDATE   = 10'h232;
  localparam logic [9:0] IDX_R_DIV    = 10'h240;
  localparam logic [9:0] IDX_DELAY    = 10'h241;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int CAL_REQ_BIT  = 0;
  localparam int CAL_DIV_LSB  = 1;
  localparam int ZD_MODE_LSB  = 1;
  localparam int ZD_CH_LSB    = 3;
  localparam int DONE_BIT     = 6;
  localparam int BUSY_BIT     = 0;
  localparam int UPDATE_BIT   = 0;
  localparam int VCO_DIV_LSB  = 0;
  localparam int R_DIV_LSB    = 0;
  localparam int R_DLY_LSB    = 0;
  localparam int N_DLY_LSB    = 4;

  // ----------------------------------------------------------------
  // encodings, reset values and counts
  // ----------------------------------------------------------------
  localparam logic [1:0]  ZD_INTERNAL   = 2'h1;
  localparam logic [1:0]  ZD_EXTERNAL   = 2'h3;
  localparam logic [13:0] R_DIV_RESET   = 14'h0001;
  localparam logic [2:0]  VCO_DIV_RESET = 3'h0;
  localparam logic [15:0] CAL_DIV_BASE  = 16'h0002;
  localparam logic [12:0] CAL_CYCLES    = 13'h1130; // 4400 calibration clocks

  // configuration that is staged by software and moved by update
  typedef struct packed {
    logic        cal_req;
    logic [1:0]  cal_div;
    logic [1:0]  zd_mode;
    logic [1:0]  zd_ch;
    logic [2:0]  vco_div;
    logic [13:0] r_div;
    logic [3:0]  r_dly;
    logic [3:0]  n_dly;
  } vcs_cfg_t;

  localparam vcs_cfg_t CFG_RESET = '{cal_req: 1'b0, cal_div: 2'h0,
                                     zd_mode: 2'h0, zd_ch: 2'h0,
                                     vco_div: VCO_DIV_RESET,
                                     r_div: R_DIV_RESET,
                                     r_dly: 4'h0, n_dly: 4'h0};

endpackage : vcs_pkg

// >>> rtl/vcs_tick_if.sv
// tick stream with divide value between sequencer and divider
interface vcs_tick_if;
  logic        clr;
  logic        tick_in;
  logic [15:0] div;
  logic        tick_out;

  modport src (output clr, output tick_in, output div, input tick_out);
  modport dst (input clr, input tick_in, input div, output tick_out);
endinterface : vcs_tick_if

// >>> rtl/vcs_tick_div.sv
// divides a tick stream by a programmable value
module vcs_tick_div
(
  input  wire logic pclk,
  input  wire logic presetn,
  vcs_tick_if.dst   tk
);

  typedef struct packed {
    logic [15:0] cnt;
    logic        tick;
  } vcs_div_st_t;

  vcs_div_st_t st;
  vcs_div_st_t next_st;
  logic [15:0] lim;

  // ----------------------------------------------------------------
  // next state: one output tick per div input ticks
  // ----------------------------------------------------------------
  always_comb
  begin
    next_st      = st;
    next_st.tick = 1'b0;
    lim          = (tk.div == 16'h0000) ? 16'h0001 : tk.div; // zero acts as one
    if (tk.clr)
    begin
      next_st.cnt = 16'h0000;
    end
    else if (tk.tick_in)
    begin
      if (st.cnt + 16'h0001 >= lim)
      begin
        next_st.cnt  = 16'h0000;
        next_st.tick = 1'b1;
      end
      else
      begin
        next_st.cnt = st.cnt + 16'h0001;
      end
    end
  end

  // state register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      st <= '0;
    else
      st <= next_st;
  end

  assign tk.tick_out = st.tick;

endmodule : vcs_tick_div

// >>> rtl/vcs_sequencer.sv
// oscillator calibration sequencer and zero delay feedback select
//
// Contract
// - calibration clock comes from divided reference
// - autoload completion starts a calibration
// - first request bit plus update starts calibration
// - later starts need transferred zero-to-one request
// - read-only completion flag reads one when finished
// - sync outputs, calibrate, release sync, close loop
// - outputs resume without waiting for lock
// - calibration clock is phase clock over divider
// - calibration lasts 4400 calibration clocks
// - no self start when loop registers change
// - internal mode feeds back channel divider zero
// - dividers one to three only in external mode
// - programmable reference and feedback path delays
// - external mode feeds back through clock pins
// - external default divider zero, calibration uses it
//
// Added by the designer: the address map and the APB interface to the registers.
module vcs_sequencer
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        reference_input_clock,
  input  wire logic        autoload_enable,
  input  wire logic        autoload_done,
  output logic             output_sync,
  output logic             loop_closed,
  output logic             cal_busy,
  output logic             feedback_source_selector,
  output logic             feedback_divider_input_selector,
  output logic      [1:0]  feedback_channel,
  output logic      [1:0]  cal_feedback_channel,
  output logic      [2:0]  vco_divider,
  output logic      [3:0]  reference_delay,
  output logic      [3:0]  feedback_delay
);

  // calibration sequence states
  typedef enum {
    ST_IDLE,
    ST_SYNC,
    ST_CAL
  } vcs_fsm_t;

  // whole module state, registered as one word
  typedef struct packed {
    // staged and active configuration
    vcs_pkg::vcs_cfg_t stage;
    vcs_pkg::vcs_cfg_t act;
    // calibration progress and held outputs
    vcs_fsm_t          fsm;
    logic [12:0]       cnt;
    logic              done;
    logic              sync;
    logic              closed;
    // reference pin synchroniser
    logic              ref_s1;
    logic              ref_s2;
    logic              ref_s3;
    // divider clear and feedback routing
    logic              div_clr;
    logic              src_sel;
    logic              in_sel;
    logic [1:0]        fb_ch;
    logic [1:0]        cal_ch;
    // bus answer
    logic              rdy;
    logic              err;
    logic [31:0]       rdata;
  } vcs_state_t;

  // registered state and its next value
  vcs_state_t st;
  vcs_state_t next_st;

  // tick streams into the two dividers
  vcs_tick_if pd_if ();
  vcs_tick_if cal_if ();

  // bus decode and start helpers
  logic        setup;
  logic        wr_acc;
  logic        mapped;
  logic        start_req;
  logic [9:0]  idx;
  logic [31:0] rd_word;

  // ----------------------------------------------------------------
  // reference edge to phase clock to calibration clock
  // ----------------------------------------------------------------
  assign pd_if.clr      = st.div_clr;
  assign pd_if.tick_in  = st.ref_s2 & ~st.ref_s3;
  assign pd_if.div      = {2'h0, st.act.r_div};
  assign cal_if.clr     = st.div_clr;
  assign cal_if.tick_in = pd_if.tick_out;
  assign cal_if.div     = vcs_pkg::CAL_DIV_BASE << st.act.cal_div;

  // reference edges to phase clock ticks
  vcs_tick_div u_pd_div
  (
    .pclk    (pclk),
    .presetn (presetn),
    .tk      (pd_if.dst)
  );

  // phase ticks to calibration clock ticks
  vcs_tick_div u_cal_div
  (
    .pclk    (pclk),
    .presetn (presetn),
    .tk      (cal_if.dst)
  );

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  assign idx    = paddr[11:2];
  assign setup  = psel & ~penable;
  assign wr_acc = psel & penable & pwrite & st.rdy & ~st.err;
  // every index that answers without error
  assign mapped = (idx == vcs_pkg::IDX_CAL_CTRL) || (idx == vcs_pkg::IDX_ZD_CTRL)
               || (idx == vcs_pkg::IDX_STATUS)   || (idx == vcs_pkg::IDX_VCO_DIV)
               || (idx == vcs_pkg::IDX_UPDATE)   || (idx == vcs_pkg::IDX_R_DIV)
               || (idx == vcs_pkg::IDX_DELAY);

  // read mux: staged values, live status
  always_comb
  begin
    rd_word = 32'h0000_0000;
    case (idx)
      vcs_pkg::IDX_CAL_CTRL:
      begin
        rd_word[vcs_pkg::CAL_REQ_BIT]                      = st.stage.cal_req;
        rd_word[vcs_pkg::CAL_DIV_LSB +: 2]                 = st.stage.cal_div;
      end
      vcs_pkg::IDX_ZD_CTRL:
      begin
        rd_word[vcs_pkg::ZD_MODE_LSB +: 2]                 = st.stage.zd_mode;
        rd_word[vcs_pkg::ZD_CH_LSB +: 2]                   = st.stage.zd_ch;
      end
      vcs_pkg::IDX_STATUS:
      begin
        rd_word[vcs_pkg::DONE_BIT] = st.done;
        rd_word[vcs_pkg::BUSY_BIT] = (st.fsm != ST_IDLE);
      end
      vcs_pkg::IDX_VCO_DIV:
        rd_word[vcs_pkg::VCO_DIV_LSB +: 3]                 = st.stage.vco_div;
      vcs_pkg::IDX_R_DIV:
        rd_word[vcs_pkg::R_DIV_LSB +: 14]                  = st.stage.r_div;
      vcs_pkg::IDX_DELAY:
      begin
        rd_word[vcs_pkg::R_DLY_LSB +: 4]                   = st.stage.r_dly;
        rd_word[vcs_pkg::N_DLY_LSB +: 4]                   = st.stage.n_dly;
      end
      default:
        rd_word = 32'h0000_0000;                           // update reads zero
    endcase
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    next_st         = st;
    start_req       = 1'b0;
    next_st.div_clr = 1'b0;

    // reference pin synchroniser and edge history
    next_st.ref_s1 = reference_input_clock;
    next_st.ref_s2 = st.ref_s1;
    next_st.ref_s3 = st.ref_s2;

    // zero wait slave: ready in the access cycle
    next_st.rdy = setup;
    next_st.err = setup & ~mapped;
    if (setup)
      next_st.rdata = mapped ? rd_word : 32'h0000_0000;

    // staged register writes
    if (wr_acc)
    begin
      case (idx)
        vcs_pkg::IDX_CAL_CTRL:
        begin
          next_st.stage.cal_req = pwdata[vcs_pkg::CAL_REQ_BIT];
          next_st.stage.cal_div = pwdata[vcs_pkg::CAL_DIV_LSB +: 2];
        end
        vcs_pkg::IDX_ZD_CTRL:
        begin
          next_st.stage.zd_mode = pwdata[vcs_pkg::ZD_MODE_LSB +: 2];
          next_st.stage.zd_ch   = pwdata[vcs_pkg::ZD_CH_LSB +: 2];
        end
        vcs_pkg::IDX_VCO_DIV:
          next_st.stage.vco_div = pwdata[vcs_pkg::VCO_DIV_LSB +: 3];
        vcs_pkg::IDX_R_DIV:
          next_st.stage.r_div   = pwdata[vcs_pkg::R_DIV_LSB +: 14];
        vcs_pkg::IDX_DELAY:
        begin
          next_st.stage.r_dly   = pwdata[vcs_pkg::R_DLY_LSB +: 4];
          next_st.stage.n_dly   = pwdata[vcs_pkg::N_DLY_LSB +: 4];
        end
        vcs_pkg::IDX_UPDATE:
        begin
          // update strobe: move every staged field at once
          if (pwdata[vcs_pkg::UPDATE_BIT])
          begin
            next_st.act = st.stage;
            // an update starts a run only on a transferred rising request
            start_req = st.stage.cal_req & ~st.act.cal_req;
          end
        end
        default:
          next_st.act = next_st.act;
      endcase
    end

    // autoload completion starts a run on its own
    if (autoload_enable && autoload_done)
      start_req = 1'b1;

    // calibration sequence
    case (st.fsm)
      ST_IDLE:
      begin
        // requests are only taken while idle
        if (start_req)
        begin
          next_st.fsm     = ST_SYNC;
          next_st.sync    = 1'b1;
          next_st.closed  = 1'b0;
          next_st.done    = 1'b0;
          next_st.div_clr = 1'b1;
        end
      end
      ST_SYNC:
      begin
        // outputs now held static, start counting
        next_st.fsm = ST_CAL;
        next_st.cnt = 13'h0000;
      end
      ST_CAL:
      begin
        if (cal_if.tick_out)
        begin
          if (st.cnt + 13'h0001 >= vcs_pkg::CAL_CYCLES)
          begin
            // release outputs at once, no lock wait
            next_st.fsm    = ST_IDLE;
            next_st.sync   = 1'b0;
            next_st.closed = 1'b1;
            next_st.done   = 1'b1;
            next_st.cnt    = 13'h0000;
          end
          else
          begin
            next_st.cnt = st.cnt + 13'h0001;
          end
        end
      end
      default:
        next_st.fsm = ST_IDLE;
    endcase

    // feedback routing from the active zero delay fields
    case (st.act.zd_mode)
      vcs_pkg::ZD_INTERNAL:
      begin
        next_st.src_sel = 1'b1;
        next_st.in_sel  = 1'b0;
        next_st.fb_ch   = 2'h0;
      end
      vcs_pkg::ZD_EXTERNAL:
      begin
        next_st.src_sel = 1'b1;
        next_st.in_sel  = 1'b1;
        next_st.fb_ch   = st.act.zd_ch;
      end
      default:
      begin
        // no zero delay: normal feedback path
        next_st.src_sel = 1'b0;
        next_st.in_sel  = 1'b0;
        next_st.fb_ch   = 2'h0;
      end
    endcase
    // calibration follows the chosen feedback divider
    if (st.act.zd_mode == vcs_pkg::ZD_EXTERNAL)
      next_st.cal_ch = st.act.zd_ch;
    else
      next_st.cal_ch = 2'h0;
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      // clear all, then load the configuration defaults
      st       <= '0;
      st.stage <= vcs_pkg::CFG_RESET;
      st.act   <= vcs_pkg::CFG_RESET;
      st.fsm   <= ST_IDLE;
    end
    else
    begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // outputs, all registered
  // ----------------------------------------------------------------
  assign prdata                          = st.rdata;
  assign pready                          = st.rdy;
  assign pslverr                         = st.err;
  assign output_sync                     = st.sync;
  assign loop_closed                     = st.closed;
  assign cal_busy                        = st.sync;
  assign feedback_source_selector        = st.src_sel;
  assign feedback_divider_input_selector = st.in_sel;
  assign feedback_channel                = st.fb_ch;
  assign cal_feedback_channel            = st.cal_ch;
  assign vco_divider                     = st.act.vco_div;
  assign reference_delay                 = st.act.r_dly;
  assign feedback_delay                  = st.act.n_dly;

endmodule : vcs_sequencer

// >>> verification/vcs_sequencer_checker.sv
// port checker for the calibration sequencer
module vcs_sequencer_checker
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        autoload_enable,
  input wire logic        autoload_done,
  input wire logic        output_sync,
  input wire logic        loop_closed,
  input wire logic        cal_busy,
  input wire logic        feedback_source_selector,
  input wire logic        feedback_divider_input_selector,
  input wire logic [1:0]  feedback_channel,
  input wire logic [1:0]  cal_feedback_channel
);
  // ----------------------------------------------------------------
  // request tracking
  // ----------------------------------------------------------------
  logic staged_req;
  logic active_req;
  logic acc;
  logic upd;
  logic start;
  // finished access, update strobe and any legal start cause
  assign acc   = psel && penable && pready;
  assign upd   = acc && pwrite && paddr[11:2] == vcs_pkg::IDX_UPDATE && pwdata[0];
  assign start = !cal_busy && ((upd && staged_req && !active_req) ||
                 (autoload_enable && autoload_done));
  // staged and transferred copies of the request bit
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      staged_req <= 1'b0;
      active_req <= 1'b0;
    end
    else
    begin
      if (acc && pwrite && paddr[11:2] == vcs_pkg::IDX_CAL_CTRL)
        staged_req <= pwdata[vcs_pkg::CAL_REQ_BIT];
      if (upd)
        active_req <= staged_req;
    end
  end

  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_start_syncs: assert property (start |=> output_sync && !loop_closed)
    else $error("calibration did not start");
  chk_no_self_start: assert property ($rose(output_sync) |-> $past(start))
    else $error("calibration started without request");
  chk_sync_open: assert property (output_sync |-> cal_busy && !loop_closed)
    else $error("loop closed while outputs held");
  chk_release_closes: assert property ($fell(output_sync) |-> loop_closed && !cal_busy)
    else $error("loop not closed at release");
  chk_done_low: assert property (acc && !pwrite && paddr[11:2] == vcs_pkg::IDX_STATUS
    && output_sync |-> !prdata[vcs_pkg::DONE_BIT] && prdata[vcs_pkg::BUSY_BIT])
    else $error("done flag set during calibration");
  chk_internal_zero: assert property (feedback_source_selector &&
    !feedback_divider_input_selector |-> feedback_channel == 2'h0 && cal_feedback_channel == 2'h0)
    else $error("internal feedback not channel zero");
  chk_ext_route: assert property (feedback_divider_input_selector |->
    feedback_source_selector && cal_feedback_channel == feedback_channel)
    else $error("external feedback route wrong");
  chk_ext_only: assert property (feedback_channel != 2'h0 |-> feedback_divider_input_selector)
    else $error("channel feedback outside external mode");
endmodule : vcs_sequencer_checker

bind vcs_sequencer vcs_sequencer_checker chk_i
(
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
  .autoload_enable, .autoload_done, .output_sync, .loop_closed, .cal_busy,
  .feedback_source_selector, .feedback_divider_input_selector,
  .feedback_channel, .cal_feedback_channel
);

// >>> verification/vcs_sequencer_test.sv
// self-checking bench for the calibration sequencer
module vcs_sequencer_test;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic        reference_input_clock = 1'b0;
  logic        autoload_enable = 1'b0;
  logic        autoload_done = 1'b0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        output_sync;
  logic        loop_closed;
  logic        cal_busy;
  logic        feedback_source_selector;
  logic        feedback_divider_input_selector;
  logic [1:0]  feedback_channel;
  logic [1:0]  cal_feedback_channel;
  logic [2:0]  vco_divider;
  logic [3:0]  reference_delay;
  logic [3:0]  feedback_delay;
  logic [31:0] rd;
  logic        err;
  logic [1:0]  ref_div = 2'h0;
  int          ref_edges = 0;
  int          cycles = 0;
  int          bad_count = 0;
  int          checks_done = 0;

  vcs_sequencer uut
  (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .reference_input_clock, .autoload_enable, .autoload_done, .output_sync,
    .loop_closed, .cal_busy, .feedback_source_selector, .feedback_divider_input_selector,
    .feedback_channel, .cal_feedback_channel, .vco_divider, .reference_delay, .feedback_delay
  );

  // pclk at 100 MHz
  always #5 pclk = ~pclk;
  // reference rises every three pclk (33 MHz); hang guard
  always @(posedge pclk)
  begin
    cycles++;
    ref_div <= (ref_div == 2'h2) ? 2'h0 : ref_div + 2'h1;
    reference_input_clock <= (ref_div == 2'h2);
    if (ref_div == 2'h2)
      ref_edges <= ref_edges + 1;
    if (cycles == 90000)
    begin
      bad_count++;
      print_verdict();
    end
  end

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : print_verdict

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp)
    begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  // one apb transfer, answer taken at the edge that sees pready
  task automatic apb(input logic w, input logic [9:0] idx, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {idx, 2'h0};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic update();
    apb(1'b1, vcs_pkg::IDX_UPDATE, 32'h1);
  endtask : update

  task automatic settle();
    repeat (2) @(posedge pclk);
    @(negedge pclk);
  endtask : settle

  task automatic do_reset();
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
  endtask : do_reset

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_regs();
    apb(1'b0, vcs_pkg::IDX_R_DIV, 32'h0);
    check("r divider reset", 32'h1, rd);
    apb(1'b1, vcs_pkg::IDX_STATUS, 32'hFFFFFFFF);
    apb(1'b0, vcs_pkg::IDX_STATUS, 32'h0);
    check("status after write", 32'h0, rd);
    apb(1'b0, 10'h100, 32'h0);
    check("unmapped error", 32'h1, {31'h0, err});
  endtask : t_regs

  // staged values reach the outputs only on update
  task automatic t_staging();
    apb(1'b1, vcs_pkg::IDX_DELAY, 32'hA5);
    apb(1'b1, vcs_pkg::IDX_VCO_DIV, 32'h3);
    settle();
    check("delay before update", 32'h0, {28'h0, reference_delay});
    update();
    settle();
    check("reference delay", 32'h5, {28'h0, reference_delay});
    check("feedback delay", 32'hA, {28'h0, feedback_delay});
    check("post divider", 32'h3, {29'h0, vco_divider});
    check("no self start", 32'h0, {31'h0, output_sync});
  endtask : t_staging

  task automatic t_zero_delay();
    logic [1:0] ext;
    for (int m = 0; m < 4; m++)
      for (int c = 0; c < 4; c++)
      begin
        apb(1'b1, vcs_pkg::IDX_ZD_CTRL, 32'((c << 3) | (m << 1)));
        update();
        settle();
        ext = (m == 3) ? 2'(c) : 2'h0;
        check("feedback source", 32'(m == 1 || m == 3), {31'h0, feedback_source_selector});
        check("external input", 32'(m == 3), {31'h0, feedback_divider_input_selector});
        check("feedback channel", 32'(ext), {30'h0, feedback_channel});
        check("calibration channel", 32'(ext), {30'h0, cal_feedback_channel});
      end
  endtask : t_zero_delay

  task automatic pulse_autoload(input logic en);
    @(posedge pclk);
    autoload_enable <= en;
    autoload_done <= 1'b1;
    @(posedge pclk);
    autoload_done <= 1'b0;
    @(negedge pclk);
  endtask : pulse_autoload

  task automatic t_autoload();
    pulse_autoload(1'b0);
    check("no start without autoload", 32'h0, {31'h0, output_sync});
    pulse_autoload(1'b1);
    check("autoload start", 32'h1, {31'h0, output_sync});
    do_reset();
  endtask : t_autoload

  // full run: reference 33 MHz, R of 3 (phase 11 MHz), code 00 (cal 5.6 MHz)
  task automatic t_first_cal();
    int s;
    int n;
    apb(1'b1, vcs_pkg::IDX_R_DIV, 32'h3);
    apb(1'b1, vcs_pkg::IDX_VCO_DIV, 32'h1);
    apb(1'b1, vcs_pkg::IDX_CAL_CTRL, 32'h1);
    update();
    @(negedge pclk);
    s = ref_edges;
    check("sync at start", 32'h1, {31'h0, output_sync});
    apb(1'b0, vcs_pkg::IDX_STATUS, 32'h0);
    check("status running", 32'h1, rd);
    n = 0;
    while (output_sync === 1'b1 && n < 85000)
    begin
      @(negedge pclk);
      n++;
    end
    n = ref_edges - s;
    n = (n >= 26398 && n <= 26402) ? 26400 : n; // synchroniser latency slack
    check("ref edges per run", 32'd26400, 32'(n));
    check("loop closed", 32'h1, {31'h0, loop_closed});
    apb(1'b0, vcs_pkg::IDX_STATUS, 32'h0);
    check("status done", 32'h40, rd);
  endtask : t_first_cal

  task automatic t_recal();
    apb(1'b1, vcs_pkg::IDX_CAL_CTRL, 32'h1);
    update();
    @(negedge pclk);
    check("repeat request ignored", 32'h0, {31'h0, output_sync});
    apb(1'b1, vcs_pkg::IDX_R_DIV, 32'h4);
    apb(1'b1, vcs_pkg::IDX_CAL_CTRL, 32'h0);
    update();
    apb(1'b1, vcs_pkg::IDX_CAL_CTRL, 32'h1);
    update();
    @(negedge pclk);
    check("second start", 32'h1, {31'h0, output_sync});
    apb(1'b0, vcs_pkg::IDX_STATUS, 32'h0);
    check("done cleared", 32'h1, rd);
    do_reset();
  endtask : t_recal

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    do_reset();
    t_regs();
    t_staging();
    t_zero_delay();
    t_autoload();
    t_first_cal();
    t_recal();
    print_verdict();
  end
endmodule : vcs_sequencer_test
